// file: wid_pkg.sv
// Package: instruction fields, opcodes and timing for the 12-bit decoder
`default_nettype none
package wid_pkg;
  localparam int INSN_W = 12;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  localparam int OSC_PER_CYCLE = 4;
  localparam int Q_W = 2;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [1:0] Q_FIRST = 2'h0;
  localparam int DEST_BIT = 5;
  localparam int BIT_LO = 5;
  localparam int BIT_HI = 7;
  // Lowest opcode bit of the byte, literal and jump formats
  localparam int BOP_LO = 6;
  localparam int LOP_LO = 8;
  localparam int JOP_LO = 9;
  localparam int PDIR_F = 6;
  // Opcodes, byte format uses bits 11..6
  localparam logic [5:0] OP_ADD_FILE = 6'h07;
  localparam logic [5:0] OP_AND_FILE = 6'h05;
  localparam logic [5:0] OP_XOR_FILE = 6'h06;
  localparam logic [5:0] OP_SWAP_FILE = 6'h0e;
  // Literal format uses bits 11..8
  localparam logic [3:0] OP_AND_LIT = 4'he;
  localparam logic [3:0] OP_XOR_LIT = 4'hf;
  // Jump uses bits 11..9
  localparam logic [2:0] OP_JUMP = 3'h5;
  // Direction load: upper nine bits zero, f field 6
  localparam logic [8:0] OP_PDIR_HI = 9'h000;
  localparam logic [11:0] PDIR_WORD = 12'h006;
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [7:0] PDIR_RESET = 8'hff;
  localparam logic [8:0] PC_RESET = 9'h1ff;

  typedef enum logic [2:0] {
    WID_NOP, WID_ADD, WID_AND, WID_XOR, WID_SWAP, WID_ANDL, WID_XORL,
    WID_PDIR
  } wid_op_type;

  // Decoded instruction fields
  typedef struct packed {
    wid_op_type op;
    logic jump;
    logic dest_file;
    logic [2:0] bit_num;
    logic [4:0] faddr;
    logic [7:0] lit8;
    logic [8:0] lit9;
  } wid_dec_type;

  // Status flags
  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } wid_flags_type;
endpackage : wid_pkg
`default_nettype wire

// file: wid_core.sv
// Decoder and execute logic for a 12-bit instruction word core
// Function
// - Take single 12-bit words: opcode plus operands
// - Byte format: opcode 11-6, d 5, f 4-0
// - d=0 writes work register, d=1 file
// - Bit format: opcode 11-8, bit 7-5, f
// - Literal format: opcode 11-8, literal 7-0
// - Jump: opcode 11-9, 9-bit target 8-0
// - One cycle; jumps take two cycles
// - Instruction cycle is four oscillator periods
// - Add work and file; update all three flags
// - AND work with file, update Z only
// - AND literal into work, update Z
// - Swap file nibbles, flags unchanged
// - f=6 loads direction register from work
// - XOR literal into work, update Z
// - XOR work with file, update Z
`timescale 1ns/1ps
`default_nettype none
module wid_core (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [11:0] insn_word,
  input wire logic [7:0] file_rdata,
  output logic [8:0] prog_addr,
  output logic [4:0] file_addr,
  output logic file_we,
  output logic [7:0] file_wdata,
  output logic [7:0] work_reg,
  output logic [7:0] port_dir,
  output wid_pkg::wid_flags_type flags,
  output logic q_end,
  output logic flush
);

  ////////////////////////////////////////////////////////////////////////
  // Quadrature divider: one enable pulse per instruction cycle
  logic [1:0] q_q, q_d;
  always_comb begin
    q_d = q_q + 2'h1;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_q <= wid_pkg::Q_FIRST;
    end else begin
      q_q <= q_d;
    end
  end
  assign q_end = (q_q == wid_pkg::Q_LAST);

  ////////////////////////////////////////////////////////////////////////
  // Field split; format chosen by opcode width
  wid_pkg::wid_dec_type dec;
  always_comb begin
    dec = '0;
    dec.dest_file = insn_word[wid_pkg::DEST_BIT];
    dec.faddr = insn_word[wid_pkg::FADDR_W-1:0];
    dec.bit_num = insn_word[wid_pkg::BIT_HI:wid_pkg::BIT_LO];
    dec.lit8 = insn_word[wid_pkg::DATA_W-1:0];
    dec.lit9 = insn_word[wid_pkg::JOP_LO-1:0];
    dec.op = wid_pkg::WID_NOP;
    dec.jump = (insn_word[wid_pkg::INSN_W-1:wid_pkg::JOP_LO]
      == wid_pkg::OP_JUMP);
    case (insn_word[wid_pkg::INSN_W-1:wid_pkg::BOP_LO])
      wid_pkg::OP_ADD_FILE: dec.op = wid_pkg::WID_ADD;
      wid_pkg::OP_AND_FILE: dec.op = wid_pkg::WID_AND;
      wid_pkg::OP_XOR_FILE: dec.op = wid_pkg::WID_XOR;
      wid_pkg::OP_SWAP_FILE: dec.op = wid_pkg::WID_SWAP;
      default: begin
        case (insn_word[wid_pkg::INSN_W-1:wid_pkg::LOP_LO])
          wid_pkg::OP_AND_LIT: dec.op = wid_pkg::WID_ANDL;
          wid_pkg::OP_XOR_LIT: dec.op = wid_pkg::WID_XORL;
          default: begin
            if (insn_word == wid_pkg::PDIR_WORD) begin
              dec.op = wid_pkg::WID_PDIR;
            end
          end
        endcase
      end
    endcase
  end
  assign file_addr = dec.faddr;

  ////////////////////////////////////////////////////////////////////////
  // Execute: result, flags and destination select
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] result;
  logic to_file, to_work, z_upd, c_upd;
  always_comb begin
    sum = {1'b0, work_reg} + {1'b0, file_rdata};
    low_sum = {1'b0, work_reg[3:0]} + {1'b0, file_rdata[3:0]};
    result = '0;
    z_upd = 1'b0;
    c_upd = 1'b0;
    to_file = 1'b0;
    to_work = 1'b0;
    case (dec.op)
      wid_pkg::WID_ADD: begin
        result = sum[7:0];
        z_upd = 1'b1;
        c_upd = 1'b1;
      end
      wid_pkg::WID_AND: begin
        result = work_reg & file_rdata;
        z_upd = 1'b1;
      end
      wid_pkg::WID_XOR: begin
        result = work_reg ^ file_rdata;
        z_upd = 1'b1;
      end
      wid_pkg::WID_SWAP: begin
        result = {file_rdata[3:0], file_rdata[7:4]};
      end
      wid_pkg::WID_ANDL: begin
        result = work_reg & dec.lit8;
        z_upd = 1'b1;
      end
      wid_pkg::WID_XORL: begin
        result = work_reg ^ dec.lit8;
        z_upd = 1'b1;
      end
      default: result = '0;
    endcase
    case (dec.op)
      wid_pkg::WID_ADD, wid_pkg::WID_AND, wid_pkg::WID_XOR,
      wid_pkg::WID_SWAP: begin
        to_file = dec.dest_file;
        to_work = !dec.dest_file;
      end
      wid_pkg::WID_ANDL, wid_pkg::WID_XORL: to_work = 1'b1;
      default: to_work = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Architectural state, committed on the last quarter
  logic [7:0] work_d, pdir_d;
  logic [8:0] pc_q, pc_d;
  logic flush_q, flush_d;
  wid_pkg::wid_flags_type flags_q, flags_d;
  logic exec;
  always_comb begin
    // The word fetched behind a jump is dropped: second cycle of the jump
    exec = q_end && !flush_q;
    work_d = work_reg;
    pdir_d = port_dir;
    flags_d = flags_q;
    pc_d = pc_q;
    flush_d = flush_q;
    if (q_end) begin
      pc_d = pc_q + 9'h001;
      flush_d = 1'b0;
      if (exec) begin
        if (to_work) work_d = result;
        if (dec.op == wid_pkg::WID_PDIR) pdir_d = work_reg;
        if (z_upd) flags_d.zero = (result == '0);
        if (c_upd) begin
          flags_d.carry = sum[8];
          flags_d.digit_carry_flag = low_sum[4];
        end
        if (dec.jump) begin
          pc_d = dec.lit9;
          flush_d = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      work_reg <= wid_pkg::WORK_RESET;
      port_dir <= wid_pkg::PDIR_RESET;
      flags_q <= '0;
      pc_q <= wid_pkg::PC_RESET;
      flush_q <= 1'b0;
    end else begin
      work_reg <= work_d;
      port_dir <= pdir_d;
      flags_q <= flags_d;
      pc_q <= pc_d;
      flush_q <= flush_d;
    end
  end
  assign flags = flags_q;
  assign prog_addr = pc_q;
  assign flush = flush_q;
  assign file_we = exec && to_file;
  assign file_wdata = result;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_quarter;
    @(posedge sys_clk) disable iff (!rst_b)
    q_end |=> !q_end [*3] ##1 q_end;
  endproperty
  a_quarter: assert property (p_quarter) else $error("cycle not 4");
  property p_jump_two;
    @(posedge sys_clk) disable iff (!rst_b)
    (exec && dec.jump) |=> flush ##3 (q_end && !file_we);
  endproperty
  a_jump_two: assert property (p_jump_two)
    else $error("jump slot ran");
  property p_dest;
    @(posedge sys_clk) disable iff (!rst_b)
    (exec && dec.op == wid_pkg::WID_ADD && !dec.dest_file)
      |=> work_reg == $past(sum[7:0]);
  endproperty
  a_dest: assert property (p_dest) else $error("add to work wrong");
  property p_file_wr;
    @(posedge sys_clk) disable iff (!rst_b)
    file_we |-> (dec.dest_file && q_end);
  endproperty
  a_file_wr: assert property (p_file_wr)
    else $error("bad file write");
  property p_zero;
    @(posedge sys_clk) disable iff (!rst_b)
    (exec && z_upd) |=> flags.zero == ($past(result) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_swap_flags;
    @(posedge sys_clk) disable iff (!rst_b)
    (exec && dec.op == wid_pkg::WID_SWAP) |=> $stable(flags);
  endproperty
  a_swap_flags: assert property (p_swap_flags)
    else $error("swap flags");
  property p_pdir;
    @(posedge sys_clk) disable iff (!rst_b)
    (exec && insn_word == wid_pkg::PDIR_WORD)
      |=> port_dir == $past(work_reg) && $stable(flags);
  endproperty
  a_pdir: assert property (p_pdir) else $error("direction load");
  property p_nop;
    @(posedge sys_clk) disable iff (!rst_b)
    (exec && dec.op == wid_pkg::WID_NOP && !dec.jump)
      |=> $stable(work_reg) && $stable(flags) && !flush;
  endproperty
  a_nop: assert property (p_nop) else $error("no-op changed state");
  property p_andl;
    @(posedge sys_clk) disable iff (!rst_b)
    (exec && insn_word[11:8] == wid_pkg::OP_AND_LIT)
      |=> work_reg == ($past(work_reg) & $past(insn_word[7:0]));
  endproperty
  a_andl: assert property (p_andl) else $error("and literal");
endmodule : wid_core
`default_nettype wire

// file: wid_file_model.sv
// Partner model: the file register space behind the decoder core
`timescale 1ns/1ps
`default_nettype none
module wid_file_model (
  input wire logic sys_clk,
  input wire logic [4:0] file_addr,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata
);
  // 32 entries, loaded by the bench so no unknown reaches the core
  logic [7:0] mem [32];
  ////////////////////////////////
  // Read is combinational; a write lands on the edge closing q_end
  assign file_rdata = mem[file_addr];
  always @(posedge sys_clk) begin
    if (file_we) mem[file_addr] <= file_wdata;
  end
endmodule : wid_file_model
`default_nettype wire

// file: test_word12_instruction_decoder.sv
// Testbench: corner and seeded random instruction streams for the core
`timescale 1ns/1ps
`default_nettype none
module test_word12_instruction_decoder;
  localparam logic [5:0] BYTE_OPS [4] = '{wid_pkg::OP_ADD_FILE,
    wid_pkg::OP_AND_FILE, wid_pkg::OP_XOR_FILE, wid_pkg::OP_SWAP_FILE};
  logic sys_clk, rst_b, file_we, q_end, flush;
  logic [11:0] insn_word, w;
  logic [7:0] file_rdata, file_wdata, work_reg, port_dir, e_work, e_pdir;
  logic [8:0] prog_addr, e_pc;
  logic [4:0] file_addr;
  wid_pkg::wid_flags_type flags, e_flg;
  int failures, tests_run, gap;
  wid_core dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .insn_word(insn_word),
    .file_rdata(file_rdata), .prog_addr(prog_addr), .file_addr(file_addr),
    .file_we(file_we), .file_wdata(file_wdata), .work_reg(work_reg),
    .port_dir(port_dir), .flags(flags), .q_end(q_end), .flush(flush));
  wid_file_model fm_u (.sys_clk(sys_clk), .file_addr(file_addr),
    .file_we(file_we), .file_wdata(file_wdata), .file_rdata(file_rdata));
  ////////////////////////////////
  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Counts, verdict and end of run
  task automatic complete_run();
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  // Case equality, so an unknown never passes for a match
  task automatic chk(input string what, input logic [8:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Expected 8-bit result, with the carry out of an add in bit 8
  function automatic logic [8:0] exp_alu(input logic [11:0] iw,
    input logic [7:0] wk, input logic [7:0] fv);
    case (iw[11:6])
      wid_pkg::OP_ADD_FILE: exp_alu = {1'b0, wk} + {1'b0, fv};
      wid_pkg::OP_AND_FILE: exp_alu = {1'b0, wk & fv};
      wid_pkg::OP_XOR_FILE: exp_alu = {1'b0, wk ^ fv};
      wid_pkg::OP_SWAP_FILE: exp_alu = {1'b0, fv[3:0], fv[7:4]};
      // Only the two literal opcodes share bits 11..9 = 111
      default: exp_alu = iw[8] ? {1'b0, wk ^ iw[7:0]} : {1'b0, wk & iw[7:0]};
    endcase
  endfunction : exp_alu
  // Present one word, wait until it is taken, then check the outcome
  task automatic run(input logic [11:0] iw);
    logic [7:0] fv, res;
    logic byte_op, upd_z, to_file, cy;
    int n;
    insn_word <= iw;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      if (q_end && flush) begin
        chk("flush_we", 9'h000, {8'h00, file_we});
        e_pc = e_pc + 9'h001;
      end
      if (n > 12) begin
        failures++;
        $display("MISMATCH q_end expected pulse seen none");
        complete_run();
      end
    end while (!(q_end && !flush));
    if (gap > 0) chk("q_gap", 9'(gap), 9'(n));
    fv = file_rdata;
    byte_op = 1'b1;
    upd_z = 1'b1;
    gap = 3;
    e_pc = e_pc + 9'h001;
    {cy, res} = exp_alu(iw, e_work, fv);
    case (iw[11:6])
      wid_pkg::OP_ADD_FILE: begin
        e_flg.carry = cy;
        e_flg.digit_carry_flag = (e_work[3:0] + fv[3:0]) > 5'h0f;
      end
      wid_pkg::OP_AND_FILE, wid_pkg::OP_XOR_FILE: upd_z = 1'b1;
      wid_pkg::OP_SWAP_FILE: upd_z = 1'b0;
      default: begin
        byte_op = 1'b0;
        upd_z = (iw[11:9] == 3'h7);
      end
    endcase
    if (iw[11:9] == wid_pkg::OP_JUMP) begin
      e_pc = iw[8:0];
      gap = 7;
    end
    if (iw == wid_pkg::PDIR_WORD) e_pdir = e_work;
    to_file = byte_op && iw[wid_pkg::DEST_BIT];
    if (upd_z) e_flg.zero = (res == 8'h00);
    chk("file_addr", {4'h0, iw[4:0]}, {4'h0, file_addr});
    chk("file_we", {8'h00, to_file}, {8'h00, file_we});
    if (to_file) begin
      chk("file_wdata", {1'b0, res}, {1'b0, file_wdata});
    end
    if ((byte_op || upd_z) && !to_file) e_work = res;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("work_reg", {1'b0, e_work}, {1'b0, work_reg});
    chk("port_dir", {1'b0, e_pdir}, {1'b0, port_dir});
    chk("prog_addr", e_pc, prog_addr);
    chk("flags", {6'h00, e_flg}, {6'h00, flags});
    @(posedge sys_clk);
  endtask : run
  ////////////////////////////////
  // Reset, corner cases, then a seeded random stream
  initial begin
    rst_b = 1'b0;
    insn_word = 12'h000;
    failures = 0;
    tests_run = 0;
    gap = 0;
    e_work = wid_pkg::WORK_RESET;
    e_pdir = wid_pkg::PDIR_RESET;
    e_pc = wid_pkg::PC_RESET;
    e_flg = '0;
    void'($urandom(79));
    for (int i = 0; i < 32; i++) fm_u.mem[i] = 8'($urandom);
    repeat (12) @(posedge sys_clk);
    chk("rst_pc", wid_pkg::PC_RESET, prog_addr);
    chk("rst_dir", {1'b0, wid_pkg::PDIR_RESET}, {1'b0, port_dir});
    rst_b <= 1'b1;
    fm_u.mem[3] <= 8'h01;
    // Zero work, direction load, all ones, add that wraps to zero
    run(12'he00);
    run(wid_pkg::PDIR_WORD);
    run(12'hfff);
    run(12'h1e3);
    run(12'h1c3);
    // Jump, with a file-writing swap waiting in the flushed slot
    run(12'ha45);
    run(12'h3a4);
    run(12'h000);
    $display("test corner done");
    repeat (400) begin
      w = 12'($urandom);
      case ($urandom % 4)
        0: w[11:6] = BYTE_OPS[w[7:6]];
        1: w[11:9] = 3'h7;
        2: w = wid_pkg::PDIR_WORD;
        default: ;
      endcase
      run(w);
    end
    $display("test random done");
    complete_run();
  end
endmodule : test_word12_instruction_decoder
`default_nettype wire
